/* File: common/dmatm_regs.svh */
`ifndef DMATM_REGS_SVH
`define DMATM_REGS_SVH
`define DMATM_OFF_MEM_ADDR 12'h000
`define DMATM_OFF_CNT 12'h004
`define DMATM_OFF_PERIPH 12'h008
`define DMATM_OFF_CTRL 12'h00C
`define DMATM_OFF_MASTER 12'h080
`define DMATM_OFF_STATUS 12'h084
`define DMATM_OFF_ADDR_B 12'h010
`define DMATM_CH_STRIDE 12'h020
`define DMATM_BIT_ENABLE 0
`define DMATM_BIT_IRQ_EN 1
`define DMATM_BIT_SIZE 2
`define DMATM_BIT_DOWN 3
`define DMATM_BIT_INC_EN 4
`define DMATM_MODE_LSB 5
`define DMATM_SRC_LSB 8
`define DMATM_BLK_LSB 16
`define DMATM_PERIPH_HIGH 16'hFFFF
`endif

/* File: common/dmatm_pkg.sv */
package dmatm_pkg;
  typedef enum logic [2:0] {
    DMATM_IO = 3'b000,
    DMATM_IDLE = 3'b001,
    DMATM_REPEAT = 3'b010,
    DMATM_NORM_BURST = 3'b100,
    DMATM_NORM_STEAL = 3'b101,
    DMATM_NORM_EXT = 3'b110,
    DMATM_BLOCK = 3'b111
  } dmatm_mode_e;
  typedef enum logic [1:0] {
    DMATM_S_IDLE = 2'b00,
    DMATM_S_READ = 2'b01,
    DMATM_S_WRITE = 2'b10,
    DMATM_S_NEXT = 2'b11
  } dmatm_state_e;
endpackage

/* File: src/dmatm_arb.sv */
module dmatm_arb (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] want,
  input wire logic busy,
  output logic [1:0] grant
);
  logic [1:0] pick;
  always_comb begin
    pick = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (want[i]) begin
        pick = 2'(i);
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant <= 2'd0;
    end else if (!busy) begin
      grant <= pick;
    end
  end
endmodule

/* File: src/dmatm_sync.sv */
module dmatm_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic d,
  output logic q
);
  logic s1_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= 1'b1;
      q <= 1'b1;
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule

/* File: src/dmatm_top.sv */
// Implementation choices: the register addresses and register access over APB.
`include "dmatm_regs.svh"
module dmatm_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] timer_unit_match,
  input wire logic serial_channel_tx_empty,
  input wire logic serial_channel_rx_full,
  input wire logic external_request_input,
  input wire logic nmi_event,
  input wire logic bus_higher_request,
  output logic bus_request,
  output logic [23:0] bus_addr,
  output logic bus_write,
  output logic bus_word,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  output logic [3:0] transfer_end_irq
);
  // ----------------------------------------------------------------------
  // Channel registers.
  // ----------------------------------------------------------------------
  logic [23:0] memory_address_r [4];
  logic [23:0] mem_start_r [4];
  logic [15:0] transfer_counter_r [4];
  logic [15:0] count_start_r [4];
  logic [7:0] peripheral_address_low_r [4];
  logic [31:0] ctrl_r [4];
  logic master_enable_bit_r;
  logic [3:0] req_pend_r;
  logic [3:0] rx_src_r;
  logic ext_sync;
  logic ext_prev_r;
  logic [1:0] grant;
  logic [1:0] cur_r;
  dmatm_pkg::dmatm_state_e state_r;
  logic [15:0] data_r;
  logic [15:0] blk_left_r;
  logic [3:0] active;
  logic [3:0] want;
  logic [3:0] trig;
  logic wr_en;
  logic [11:0] off;
  logic [1:0] wch;
  logic done_pulse;
  logic last_unit;
  dmatm_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(external_request_input),
    .q(ext_sync)
  );
  // ----------------------------------------------------------------------
  // Request decode.
  // ----------------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign off = paddr & 12'h01F;
  assign wch = paddr[6:5];
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      logic [2:0] md;
      logic [2:0] src;
      md = ctrl_r[c][`DMATM_MODE_LSB +: 3];
      src = ctrl_r[c][`DMATM_SRC_LSB +: 3];
      active[c] = master_enable_bit_r && ctrl_r[c][`DMATM_BIT_ENABLE];
      trig[c] = 1'b0;
      case (src)
        3'd0, 3'd1, 3'd2, 3'd3: trig[c] = timer_unit_match[src[1:0]];
        3'd4: trig[c] = serial_channel_tx_empty;
        3'd5: trig[c] = serial_channel_rx_full;
        3'd6: trig[c] = ext_prev_r && !ext_sync;
        default: trig[c] = !ext_sync;
      endcase
      // Auto-request needs no trigger; only channels 0 and 2 head a pair.
      if (md == 3'b100 || md == 3'b101) begin
        trig[c] = (c % 2 == 0);
      end
      if (md[2] && (c % 2 == 1)) begin
        trig[c] = 1'b0;
      end
      want[c] = active[c] && (trig[c] || req_pend_r[c]);
    end
  end
  dmatm_arb u_arb (
    .clk(clk),
    .reset_n(reset_n),
    .want(want),
    .busy(state_r != dmatm_pkg::DMATM_S_IDLE),
    .grant(grant)
  );
  // ----------------------------------------------------------------------
  // Register bus.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        if (paddr == `DMATM_OFF_MASTER) begin
          prdata <= {31'd0, master_enable_bit_r};
        end else if (paddr == `DMATM_OFF_STATUS) begin
          prdata <= {26'd0, state_r, cur_r, 2'b00} >> 2;
        end else if (paddr < 12'h080) begin
          case (off)
            `DMATM_OFF_MEM_ADDR: prdata <= {8'd0, memory_address_r[wch]};
            `DMATM_OFF_CNT: prdata <= {16'd0, transfer_counter_r[wch]};
            `DMATM_OFF_PERIPH: prdata <= {24'd0, peripheral_address_low_r[wch]};
            `DMATM_OFF_CTRL: prdata <= ctrl_r[wch];
            default: prdata <= 32'h0000_0000;
          endcase
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end
  // Master enable: cleared by an NMI, set again by software.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      master_enable_bit_r <= 1'b0;
    end else if (nmi_event) begin
      master_enable_bit_r <= 1'b0;
    end else if (wr_en && pready && paddr == `DMATM_OFF_MASTER) begin
      master_enable_bit_r <= pwdata[0];
    end
  end
  // ----------------------------------------------------------------------
  // Transfer engine.
  // ----------------------------------------------------------------------
  assign last_unit = (blk_left_r == 16'd1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_r <= 1'b1;
    end else begin
      ext_prev_r <= ext_sync;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= dmatm_pkg::DMATM_S_IDLE;
      cur_r <= 2'd0;
      data_r <= 16'h0000;
      bus_request <= 1'b0;
      bus_addr <= 24'h00_0000;
      bus_write <= 1'b0;
      bus_word <= 1'b0;
      bus_wdata <= 16'h0000;
      blk_left_r <= 16'h0000;
      transfer_end_irq <= 4'h0;
      req_pend_r <= 4'h0;
      rx_src_r <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        memory_address_r[c] <= 24'h00_0000;
        mem_start_r[c] <= 24'h00_0000;
        transfer_counter_r[c] <= 16'h0000;
        count_start_r[c] <= 16'h0000;
        peripheral_address_low_r[c] <= 8'h00;
        ctrl_r[c] <= 32'h0000_0000;
      end
    end else begin
      transfer_end_irq <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        if (trig[c] && active[c]) begin
          req_pend_r[c] <= 1'b1;
          rx_src_r[c] <= (ctrl_r[c][`DMATM_SRC_LSB +: 3] == 3'd5);
        end
      end
      if (wr_en && pready && paddr < 12'h080) begin
        case (off)
          `DMATM_OFF_MEM_ADDR: begin
            memory_address_r[wch] <= pwdata[23:0];
            mem_start_r[wch] <= pwdata[23:0];
          end
          `DMATM_OFF_CNT: begin
            transfer_counter_r[wch] <= pwdata[15:0];
            count_start_r[wch] <= pwdata[15:0];
          end
          `DMATM_OFF_PERIPH: peripheral_address_low_r[wch] <= pwdata[7:0];
          `DMATM_OFF_CTRL: ctrl_r[wch] <= pwdata;
          default: ;
        endcase
      end
      case (state_r)
        dmatm_pkg::DMATM_S_IDLE: begin
          // The arbiter's grant is registered, so wait until it names a
          // channel that really asks.
          if (want[grant]) begin
            cur_r <= grant;
            req_pend_r[grant] <= 1'b0;
            blk_left_r <= (ctrl_r[grant][`DMATM_MODE_LSB +: 3] == 3'b111) ?
              {8'd0, ctrl_r[grant][`DMATM_BLK_LSB +: 8]} : 16'd1;
            state_r <= dmatm_pkg::DMATM_S_READ;
          end
        end
        dmatm_pkg::DMATM_S_READ: begin
          bus_request <= 1'b1;
          bus_write <= 1'b0;
          bus_word <= ctrl_r[cur_r][`DMATM_BIT_SIZE];
          // Serial receive reads from the peripheral side.
          bus_addr <= rx_src_r[cur_r] ?
            {`DMATM_PERIPH_HIGH, peripheral_address_low_r[cur_r]} :
            memory_address_r[cur_r];
          if (bus_request && bus_ack) begin
            data_r <= bus_rdata;
            bus_request <= 1'b0;
            state_r <= dmatm_pkg::DMATM_S_WRITE;
          end
        end
        dmatm_pkg::DMATM_S_WRITE: begin
          bus_request <= 1'b1;
          bus_write <= 1'b1;
          bus_wdata <= data_r;
          bus_addr <= rx_src_r[cur_r] ? memory_address_r[cur_r] :
            {`DMATM_PERIPH_HIGH, peripheral_address_low_r[cur_r]};
          if (ctrl_r[cur_r][`DMATM_MODE_LSB + 2]) begin
            // Full-address mode writes to the partner channel's address.
            bus_addr <= memory_address_r[{cur_r[1], 1'b1}];
          end
          if (bus_request && bus_ack) begin
            bus_request <= 1'b0;
            state_r <= dmatm_pkg::DMATM_S_NEXT;
          end
        end
        dmatm_pkg::DMATM_S_NEXT: begin
          if (ctrl_r[cur_r][`DMATM_MODE_LSB +: 3] != 3'b001 &&
              ctrl_r[cur_r][`DMATM_BIT_INC_EN]) begin
            memory_address_r[cur_r] <= ctrl_r[cur_r][`DMATM_BIT_DOWN] ?
              memory_address_r[cur_r] -
                (ctrl_r[cur_r][`DMATM_BIT_SIZE] ? 24'd2 : 24'd1) :
              memory_address_r[cur_r] +
                (ctrl_r[cur_r][`DMATM_BIT_SIZE] ? 24'd2 : 24'd1);
          end
          blk_left_r <= blk_left_r - 16'd1;
          if (ctrl_r[cur_r][`DMATM_MODE_LSB +: 3] == 3'b111 && last_unit) begin
            memory_address_r[cur_r] <= mem_start_r[cur_r];
          end
          if (last_unit) begin
            // A start of zero wraps through 65,536 units.
            transfer_counter_r[cur_r] <= transfer_counter_r[cur_r] - 16'd1;
            if (transfer_counter_r[cur_r] == 16'd1) begin
              if (ctrl_r[cur_r][`DMATM_MODE_LSB +: 3] == 3'b010) begin
                memory_address_r[cur_r] <= mem_start_r[cur_r];
                transfer_counter_r[cur_r] <= count_start_r[cur_r];
              end else begin
                ctrl_r[cur_r][`DMATM_BIT_ENABLE] <= 1'b0;
                req_pend_r[cur_r] <= 1'b0;
                transfer_end_irq[cur_r] <=
                  ctrl_r[cur_r][`DMATM_BIT_IRQ_EN];
              end
            end
            state_r <= dmatm_pkg::DMATM_S_IDLE;
          end else if (ctrl_r[cur_r][`DMATM_MODE_LSB +: 3] == 3'b100 &&
                       bus_higher_request) begin
            state_r <= dmatm_pkg::DMATM_S_IDLE;
          end else begin
            state_r <= dmatm_pkg::DMATM_S_READ;
          end
        end
        default: state_r <= dmatm_pkg::DMATM_S_IDLE;
      endcase
    end
  end
endmodule

/* File: sim/dmatm_bus_model.sv */
module dmatm_bus_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_request,
  input wire logic [23:0] bus_addr,
  input wire logic bus_write,
  output logic [15:0] bus_rdata,
  output logic bus_ack,
  output logic [23:0] rd_addr,
  output logic [23:0] wr_addr,
  output logic [7:0] wr_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Slave that answers fast and slow in turn.
  // ----------------------------------------
  logic [1:0] wait_r;
  logic slow_r;
  assign bus_rdata = bus_ack ? bus_addr[15:0] ^ 16'h5a5a :
                     ~(bus_addr[15:0] ^ 16'h5a5a);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
      wait_r <= 2'd0;
      slow_r <= 1'b0;
    end else if (bus_ack || !bus_request) begin
      bus_ack <= 1'b0;
      wait_r <= {slow_r, 1'b0};
    end else if (wait_r != 2'd0) begin
      wait_r <= wait_r - 2'd1;
    end else begin
      bus_ack <= 1'b1;
      slow_r <= !slow_r;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_cnt <= 8'h00;
      wr_addr <= 24'h00_0000;
      rd_addr <= 24'h00_0000;
    end else if (bus_request && bus_ack && bus_write) begin
      wr_addr <= bus_addr;
      wr_cnt <= wr_cnt + 8'h01;
    end else if (bus_request && bus_ack) begin
      rd_addr <= bus_addr;
    end
  end
endmodule

/* File: sim/dmatm_top_chk.sv */
module dmatm_top_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_request,
  input wire logic [23:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_word,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic [3:0] transfer_end_irq
);
  // ----------------------------------------
  // Port relations of the register bus and the transfer engine.
  // ----------------------------------------
  logic [23:0] rd_addr_r;
  logic [15:0] rd_data_r;
  logic [3:0] since_wr_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_addr_r <= 24'h00_0000;
      rd_data_r <= 16'h0000;
    end else if (bus_request && bus_ack && !bus_write) begin
      rd_addr_r <= bus_addr;
      rd_data_r <= bus_rdata;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_wr_r <= 4'hf;
    end else if (bus_request && bus_ack && bus_write) begin
      since_wr_r <= 4'h0;
    end else if (since_wr_r != 4'hf) begin
      since_wr_r <= since_wr_r + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  apb_once_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  no_slverr_a: assert property (!pslverr)
    else $error("pslverr raised");
  req_hold_a: assert property (
    bus_request && !bus_ack |=>
      bus_request && $stable(bus_addr) && $stable(bus_write))
    else $error("bus request changed before ack");
  read_write_a: assert property (
    bus_request && bus_ack && !bus_write |-> ##[1:3] bus_request && bus_write)
    else $error("no write after read");
  word_copy_a: assert property (
    bus_request && bus_write && bus_word |-> bus_wdata == rd_data_r)
    else $error("write data differs from read data");
  periph_high_a: assert property (
    bus_request && bus_ack && bus_write |->
      rd_addr_r[23:8] == 16'hffff || bus_addr[23:8] == 16'hffff)
    else $error("peripheral side lacks ones above low byte");
  irq_pulse_a: assert property (
    transfer_end_irq != 4'h0 |=> transfer_end_irq == 4'h0)
    else $error("end interrupt longer than one cycle");
  irq_prompt_a: assert property (
    transfer_end_irq != 4'h0 |-> since_wr_r <= 4'h4)
    else $error("end interrupt not tied to last transfer");
endmodule

bind dmatm_top dmatm_top_chk u_chk (
  .clk(clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .bus_request(bus_request),
  .bus_addr(bus_addr),
  .bus_write(bus_write),
  .bus_word(bus_word),
  .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata),
  .bus_ack(bus_ack),
  .transfer_end_irq(transfer_end_irq)
);

/* File: sim/tb_dma_channel_transfer_modes.sv */
`include "dmatm_regs.svh"
module tb_dma_channel_transfer_modes;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Stimulus, bus master and scenarios.
  // ----------------------------------------
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, tx = 1'b0, rx = 1'b0, ext_n = 1'b1, nmi = 1'b0;
  logic clr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0] tmr = 4'h0, irq, irq_seen = 4'h0;
  logic pready, pslverr, breq, bwr, bword, back;
  logic [23:0] baddr, rda, wra;
  logic [15:0] bwd, brd;
  logic [7:0] wcnt;
  int mismatches = 0, checks = 0;
  always #20 clk = ~clk;
  always @(posedge clk) irq_seen <= clr ? 4'h0 : irq_seen | irq;
  dmatm_top DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_unit_match(tmr), .serial_channel_tx_empty(tx),
    .serial_channel_rx_full(rx), .external_request_input(ext_n),
    .nmi_event(nmi), .bus_higher_request(1'b0), .bus_request(breq),
    .bus_addr(baddr), .bus_write(bwr), .bus_word(bword), .bus_wdata(bwd),
    .bus_rdata(brd), .bus_ack(back), .transfer_end_irq(irq));
  dmatm_bus_model u_mem (.clk(clk), .reset_n(reset_n), .bus_request(breq),
    .bus_addr(baddr), .bus_write(bwr), .bus_rdata(brd), .bus_ack(back),
    .rd_addr(rda), .wr_addr(wra), .wr_cnt(wcnt));
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(q & m, e);
  endtask
  task automatic cfg(input int c, input logic [31:0] m, n, p, k);
    logic [11:0] b;
    logic [31:0] q;
    b = 12'(c * 32);
    apb(1'b1, b + `DMATM_OFF_MEM_ADDR, m, q);
    apb(1'b1, b + `DMATM_OFF_CNT, n, q);
    apb(1'b1, b + `DMATM_OFF_PERIPH, p, q);
    apb(1'b1, b + `DMATM_OFF_CTRL, k, q);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic unit(input int s, input logic e);
    logic [7:0] w0;
    logic moved;
    w0 = wcnt;
    moved = 1'b0;
    @(posedge clk);
    if (s < 4) tmr <= 4'h1 << s;
    else if (s == 4) tx <= 1'b1;
    else if (s == 5) rx <= 1'b1;
    else ext_n <= 1'b0;
    @(posedge clk);
    {tmr, tx, rx, ext_n} <= 7'b000_0001;
    for (int i = 0; i < 30 && !moved; i++) begin
      @(posedge clk);
      moved = (wcnt !== w0);
    end
    repeat (4) @(posedge clk);
    chk({31'h0, moved}, {31'h0, e});
  endtask
  task automatic s_io_tx();
    cfg(0, 32'h0001_0010, 32'h0000_0003, 32'h0000_0034, 32'h0000_0013);
    rdchk(`DMATM_OFF_CNT, 32'h0000_ffff, 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      unit(0, 1'b1);
      chk({8'h00, wra}, 32'h00ff_ff34);
      chk({8'h00, rda}, 32'h0001_0010 + i);
    end
    chk({28'h0, irq_seen}, 32'h0000_0001);
    rdchk(`DMATM_OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
    rdchk(`DMATM_OFF_CNT, 32'h0000_ffff, 32'h0000_0000);
    unit(0, 1'b0);
    rdchk(12'h0fc, 32'hffff_ffff, 32'h0000_0000);
  endtask
  task automatic s_io_rx();
    cfg(1, 32'h0002_0100, 32'h0000_0002, 32'h0000_0056, 32'h0000_051d);
    for (int i = 0; i < 2; i++) begin
      unit(5, 1'b1);
      chk({8'h00, rda}, 32'h00ff_ff56);
      chk({8'h00, wra}, 32'h0002_0100 - 2 * i);
    end
    chk({28'h0, irq_seen}, 32'h0000_0000);
  endtask
  task automatic s_idle();
    cfg(2, 32'h0003_0200, 32'h0000_0002, 32'h0000_0078, 32'h0000_0431);
    for (int i = 0; i < 2; i++) begin
      unit(4, 1'b1);
      chk({8'h00, rda}, 32'h0003_0200);
      chk({8'h00, wra}, 32'h00ff_ff78);
    end
  endtask
  task automatic s_repeat();
    cfg(3, 32'h0004_0300, 32'h0000_0002, 32'h0000_009a, 32'h0000_0653);
    for (int i = 0; i < 3; i++) begin
      unit(6, 1'b1);
      chk({8'h00, rda}, 32'h0004_0300 + i % 2);
    end
    chk({28'h0, irq_seen}, 32'h0000_0000);
  endtask
  task automatic s_nmi();
    logic [31:0] q;
    @(posedge clk);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    rdchk(`DMATM_OFF_MASTER, 32'h0000_0001, 32'h0000_0000);
    cfg(0, 32'h0001_0000, 32'h0000_0001, 32'h0000_0011, 32'h0000_0011);
    unit(0, 1'b0);
    apb(1'b1, `DMATM_OFF_MASTER, 32'h0000_0001, q);
    unit(0, 1'b1);
    rdchk(`DMATM_OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic s_burst();
    logic [7:0] w0;
    cfg(1, 32'h00ff_ff40, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    w0 = wcnt;
    cfg(0, 32'h0006_0000, 32'h0000_0003, 32'h0000_0000, 32'h0000_0091);
    for (int i = 0; i < 200 && wcnt !== w0 + 8'd3; i++) @(posedge clk);
    chk({24'h0, wcnt}, {24'h0, w0 + 8'd3});
    chk({8'h00, wra}, 32'h00ff_ff40);
    chk({8'h00, rda}, 32'h0006_0002);
    rdchk(`DMATM_OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
  endtask
  initial begin
    logic [31:0] q;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b1, `DMATM_OFF_MASTER, 32'h0000_0001, q);
    s_io_tx();
    s_io_rx();
    s_idle();
    s_repeat();
    s_nmi();
    s_burst();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
